/* File: core/rvp_pkg.sv */
// package: register map, field layout, reset values and timing for rvp block
package rvp_pkg;
  // ----------------------------------------------------------------------
  // register addresses and widths
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W          = 4;
  localparam int unsigned DATA_W          = 11;
  localparam logic [3:0]  ADDR_OPERATION  = 4'h9;
  localparam logic [3:0]  ADDR_REG_CTRL   = 4'hb;
  localparam logic [3:0]  ADDR_VDS_CTRL   = 4'hc;
  // ----------------------------------------------------------------------
  // operation register bits (write strobes only here)
  // ----------------------------------------------------------------------
  localparam int unsigned OP_SLEEP_BIT    = 2;
  localparam int unsigned OP_CLEAR_BIT    = 1;
  // ----------------------------------------------------------------------
  // regulator control fields
  // ----------------------------------------------------------------------
  localparam int unsigned RC_RSVD_HI_BIT  = 10;
  localparam int unsigned RC_SCALE_LSB    = 8;
  localparam int unsigned RC_RSVD_LSB     = 5;
  localparam int unsigned RC_DLY_LSB      = 3;
  localparam int unsigned RC_UVDIS_BIT    = 2;
  localparam int unsigned RC_UVTH_LSB     = 0;
  localparam logic [1:0]  RC_SCALE_RST    = 2'h1;
  localparam logic [1:0]  RC_DLY_RST      = 2'h1;
  localparam logic        RC_UVDIS_RST    = 1'h0;
  localparam logic [1:0]  RC_UVTH_RST     = 2'h2;
  // ----------------------------------------------------------------------
  // drain-source sense control fields
  // ----------------------------------------------------------------------
  localparam int unsigned VC_REV_LSB      = 8;
  localparam int unsigned VC_THR_LSB      = 3;
  localparam int unsigned VC_MODE_LSB     = 0;
  localparam logic [4:0]  VC_THR_RST      = 5'h19;
  localparam logic [2:0]  VC_MODE_RST     = 3'h0;
  localparam logic [2:0]  MODE_LATCH      = 3'h0;
  localparam logic [2:0]  MODE_REPORT     = 3'h1;
  localparam logic [2:0]  MODE_OFF        = 3'h2;
  // ----------------------------------------------------------------------
  // power-down delay times and cycle counts at 100 MHz
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned DLY_10_US       = 10;
  localparam int unsigned DLY_50_US       = 50;
  localparam int unsigned DLY_1_MS        = 1;
  localparam int unsigned CYC_10_US       = DLY_10_US * CLK_MHZ;
  localparam int unsigned CYC_50_US       = DLY_50_US * CLK_MHZ;
  localparam int unsigned CYC_1_MS        = DLY_1_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W           = 17;
  typedef enum logic [1:0] {RVP_AWAKE, RVP_WAIT, RVP_DOWN} rvp_slp_t;
endpackage

/* File: core/rvp_regs.sv */
// module: regulator and drain-source protection register bank
// ----------------------------------------------------------------------
// Overview of operation
// - reference scaling field 9:8 resets to 01; codes 01/10/11 give 2/4/8.
// - after sleep request, wait 0, 10 us, 50 us or 1 ms, then regulator off.
// - bit 2 set suppresses regulator undervoltage fault and its report.
// - undervoltage threshold 1:0 resets to 10; 00=0.9, 01=0.8, else 0.7.
// - bits 10:8 of sense control read revision id and ignore writes.
// - five-bit trip threshold in 7:3 resets to 0x19, picks comparator level.
// - mode 000 latches driver shutdown on overcurrent until faults cleared.
// - mode 001 only reports overcurrent; drivers keep running.
// - mode 010 disables overcurrent sensing and reporting.
// - each transistor's comparator trip is handled per response mode.
// - writing sleep bit 1 requests sleep and starts the power-down delay.
// - writing fault-clear 1 clears latched faults; 0 changes nothing.
// ----------------------------------------------------------------------
`timescale 1ns/10ps
module rvp_regs #(
  parameter logic [2:0] REV_ID  = 3'h0,  // arbitrary value
  parameter int unsigned T10US  = rvp_pkg::CYC_10_US,
  parameter int unsigned T50US  = rvp_pkg::CYC_50_US,
  parameter int unsigned T1MS   = rvp_pkg::CYC_1_MS
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [10:0] wdata_i,
  output logic      [10:0] rdata_o,
  input  wire logic [5:0]  vds_trip_i,
  input  wire logic        reg_uv_i,
  output logic      [1:0]  vref_scale_o,
  output logic      [1:0]  regulator_uv_threshold_sel_o,
  output logic      [4:0]  drain_source_trip_threshold_o,
  output logic             vds_sense_en_o,
  output logic             driver_shutdown_o,
  output logic             overcurrent_fault_o,
  output logic             regulator_undervoltage_fault_o,
  output logic             regulator_enable_o
);
  // a one-cycle wait would break the two-cycle hold that sleep_wait_a checks
  if (T1MS >= (1 << rvp_pkg::CNT_W) || T10US < 2 || T50US < T10US
      || T1MS < T50US) begin : g_bad_dly
    $error("rvp_regs: delay counts out of range");
  end

  default clocking rvp_cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  typedef struct packed {
    logic [1:0]        scale;
    logic [2:0]        rsvd_mid;
    logic              rsvd_hi;
    logic [1:0]        dly;
    logic              uv_dis;
    logic [1:0]        uv_th;
    logic [4:0]        thr;
    logic [2:0]        mode;
    logic              shut;
    logic              oc_flt;
    logic              uv_flt;
    rvp_pkg::rvp_slp_t slp;
    logic [16:0]       cnt;
    logic [10:0]       rdata;
  } rvp_state_t;

  rvp_state_t st;
  rvp_state_t next_st;
  logic       wr_rc;
  logic       wr_vc;
  logic       wr_op;
  logic       trip;
  logic [16:0] dly_cyc;

  assign wr_rc = wr_i && addr_i == rvp_pkg::ADDR_REG_CTRL;
  assign wr_vc = wr_i && addr_i == rvp_pkg::ADDR_VDS_CTRL;
  assign wr_op = wr_i && addr_i == rvp_pkg::ADDR_OPERATION;
  // comparator trips only count while sensing is on
  assign trip  = |vds_trip_i && st.mode != rvp_pkg::MODE_OFF;

  always_comb begin
    unique case (st.dly)
      2'h0:    dly_cyc = 17'h0;
      2'h1:    dly_cyc = 17'(T10US);
      2'h2:    dly_cyc = 17'(T50US);
      default: dly_cyc = 17'(T1MS);
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (wr_rc) begin
      next_st.rsvd_hi  = wdata_i[rvp_pkg::RC_RSVD_HI_BIT];
      next_st.scale    = wdata_i[rvp_pkg::RC_SCALE_LSB +: 2];
      next_st.rsvd_mid = wdata_i[rvp_pkg::RC_RSVD_LSB +: 3];
      next_st.dly      = wdata_i[rvp_pkg::RC_DLY_LSB +: 2];
      next_st.uv_dis   = wdata_i[rvp_pkg::RC_UVDIS_BIT];
      next_st.uv_th    = wdata_i[rvp_pkg::RC_UVTH_LSB +: 2];
    end
    if (wr_vc) begin
      // revision bits are not stored, so writes cannot reach them
      next_st.thr  = wdata_i[rvp_pkg::VC_THR_LSB +: 5];
      next_st.mode = wdata_i[rvp_pkg::VC_MODE_LSB +: 3];
    end
    // fault clear first, so a trip in the same cycle still sets
    if (wr_op && wdata_i[rvp_pkg::OP_CLEAR_BIT]) begin
      next_st.shut   = 1'b0;
      next_st.oc_flt = 1'b0;
      next_st.uv_flt = 1'b0;
    end
    if (trip) begin
      next_st.oc_flt = 1'b1;
      if (st.mode == rvp_pkg::MODE_LATCH)
        next_st.shut = 1'b1;
    end
    if (reg_uv_i && !st.uv_dis)
      next_st.uv_flt = 1'b1;
    if (st.uv_dis)
      next_st.uv_flt = 1'b0;
    // sleep sequencing
    if (wr_op && !wdata_i[rvp_pkg::OP_SLEEP_BIT]) begin
      next_st.slp = rvp_pkg::RVP_AWAKE;
      next_st.cnt = 17'h0;
    end else begin
      unique case (st.slp)
        rvp_pkg::RVP_AWAKE: begin
          if (wr_op) begin
            next_st.slp = (dly_cyc == 17'h0) ? rvp_pkg::RVP_DOWN
                                             : rvp_pkg::RVP_WAIT;
            next_st.cnt = 17'h1;
          end
        end
        rvp_pkg::RVP_WAIT: begin
          if (st.cnt >= dly_cyc)
            next_st.slp = rvp_pkg::RVP_DOWN;
          else
            next_st.cnt = st.cnt + 17'h1;
        end
        rvp_pkg::RVP_DOWN: next_st.slp = rvp_pkg::RVP_DOWN;
      endcase
    end
    // read data registered one cycle after rd_i
    next_st.rdata = 11'h0;
    if (rd_i) begin
      unique case (addr_i)
        rvp_pkg::ADDR_REG_CTRL:
          next_st.rdata = {st.rsvd_hi, st.scale, st.rsvd_mid, st.dly,
                           st.uv_dis, st.uv_th};
        rvp_pkg::ADDR_VDS_CTRL:
          next_st.rdata = {REV_ID, st.thr, st.mode};
        default: next_st.rdata = 11'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st        <= '0;
      st.scale  <= rvp_pkg::RC_SCALE_RST;
      st.dly    <= rvp_pkg::RC_DLY_RST;
      st.uv_dis <= rvp_pkg::RC_UVDIS_RST;
      st.uv_th  <= rvp_pkg::RC_UVTH_RST;
      st.thr    <= rvp_pkg::VC_THR_RST;
      st.mode   <= rvp_pkg::VC_MODE_RST;
      st.slp    <= rvp_pkg::RVP_AWAKE;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o                        = st.rdata;
  assign vref_scale_o                   = st.scale;
  assign regulator_uv_threshold_sel_o   = st.uv_th;
  assign drain_source_trip_threshold_o  = st.thr;
  assign vds_sense_en_o                 = st.mode != rvp_pkg::MODE_OFF;
  assign driver_shutdown_o              = st.shut;
  assign overcurrent_fault_o            = st.oc_flt;
  assign regulator_undervoltage_fault_o = st.uv_flt;
  assign regulator_enable_o             = st.slp != rvp_pkg::RVP_DOWN;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence latch_trip_s;
    trip && st.mode == rvp_pkg::MODE_LATCH;
  endsequence
  // clear with no new event alongside, since a same-cycle event wins
  sequence clear_wr_s;
    wr_op && wdata_i[rvp_pkg::OP_CLEAR_BIT] && !trip
    && !(reg_uv_i && !st.uv_dis);
  endsequence

  latch_shut_a: assert property (latch_trip_s |=> driver_shutdown_o)
    else $error("no latched shutdown");
  shut_hold_a: assert property (
    driver_shutdown_o && !(wr_op && wdata_i[rvp_pkg::OP_CLEAR_BIT])
    |=> driver_shutdown_o) else $error("shutdown dropped without clear");
  fault_clear_a: assert property (
    clear_wr_s |=> !driver_shutdown_o && !overcurrent_fault_o
    && !regulator_undervoltage_fault_o) else $error("faults not cleared");
  report_only_a: assert property (
    trip && st.mode == rvp_pkg::MODE_REPORT && !driver_shutdown_o
    |=> overcurrent_fault_o && !driver_shutdown_o)
    else $error("report mode misbehaved");
  sense_off_a: assert property (
    st.mode == rvp_pkg::MODE_OFF && !overcurrent_fault_o && !wr_vc
    |=> !overcurrent_fault_o) else $error("fault with sensing off");
  uv_mask_a: assert property (
    st.uv_dis |=> !regulator_undervoltage_fault_o)
    else $error("uv fault while disabled");
  rev_read_a: assert property (
    rd_i && addr_i == rvp_pkg::ADDR_VDS_CTRL |=> rdata_o[10:8] == REV_ID)
    else $error("revision bits wrong");
  zero_dly_a: assert property (
    st.slp == rvp_pkg::RVP_AWAKE && st.dly == 2'h0 && wr_op
    && wdata_i[rvp_pkg::OP_SLEEP_BIT] |=> !regulator_enable_o)
    else $error("zero delay not immediate");
  sleep_wait_a: assert property (
    st.slp == rvp_pkg::RVP_AWAKE && st.dly != 2'h0 && wr_op
    && wdata_i[rvp_pkg::OP_SLEEP_BIT] |=> regulator_enable_o [*2])
    else $error("regulator off too early");
endmodule // rvp_regs

/* File: test/rvp_host.sv */
// host controller model driving the register port of the rvp block
`timescale 1ns/10ps
module rvp_host (
  input  wire logic        mclk_i,
  input  wire logic [10:0] rdata_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [3:0]  addr_o,
  output logic      [10:0] wdata_o
);
  // ----------------------------------------------------------------------
  // bus cycles: one edge per request; released lines show inverted values
  // ----------------------------------------------------------------------
  initial begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = 4'h0;
    wdata_o = 11'h000;
  end
  task automatic wr_reg(input logic [3:0] a, input logic [10:0] d);
    @(posedge mclk_i);
    wr_o    <= 1'b1;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge mclk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [10:0] d);
    @(posedge mclk_i);
    rd_o   <= 1'b1;
    addr_o <= a;
    @(posedge mclk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
  // only the sleep and clear bits are ever set; the rest stay zero
  task automatic sleep_req(input logic s);
    wr_reg(rvp_pkg::ADDR_OPERATION, {8'h00, s, 2'h0});
  endtask
  task automatic clear_faults();
    wr_reg(rvp_pkg::ADDR_OPERATION, 11'h002);
  endtask
endmodule // rvp_host

/* File: test/tb.sv */
// self-checking testbench for the rvp register bank
`timescale 1ns/10ps
module tb;
  localparam int unsigned TA = 4;
  localparam int unsigned TB = 8;
  localparam int unsigned TC = 16;
  logic        mclk_i, rst_n_i, wr_i, rd_i, reg_uv_i, sd, ocf, uvf, sen, ren;
  logic [3:0]  addr_i;
  logic [10:0] wdata_i, rdata_o, v;
  logic [5:0]  vds_trip_i;
  logic [1:0]  vsc, uvth;
  logic [4:0]  thr;
  logic [4:0]  flg;
  int          error_cnt, cmp_count, cyc;
  assign flg = {sd, ocf, uvf, sen, ren};
  rvp_regs #(.T10US(TA), .T50US(TB), .T1MS(TC)) i_rvp_regs (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .vds_trip_i(vds_trip_i), .reg_uv_i(reg_uv_i), .vref_scale_o(vsc),
    .regulator_uv_threshold_sel_o(uvth), .drain_source_trip_threshold_o(thr),
    .vds_sense_en_o(sen), .driver_shutdown_o(sd),
    .overcurrent_fault_o(ocf), .regulator_undervoltage_fault_o(uvf),
    .regulator_enable_o(ren));
  rvp_host i_rvp_host (.mclk_i(mclk_i), .rdata_i(rdata_o), .wr_o(wr_i),
    .rd_o(rd_i), .addr_o(addr_i), .wdata_o(wdata_i));
  // ----------------------------------------------------------------------
  // clock, watchdog, compare and verdict
  // ----------------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // comparator inputs change at an edge and settle two edges later
  task automatic drive(input logic [5:0] t, input logic u);
    @(posedge mclk_i);
    vds_trip_i <= t;
    reg_uv_i   <= u;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    i_rvp_host.rd_reg(4'hb, v);
    chk(v, 11'h10a);
    i_rvp_host.rd_reg(4'hc, v);
    chk(v, 11'h0c8);
    i_rvp_host.rd_reg(4'h5, v);
    chk(v, 11'h000);
    chk({2'h0, thr, vsc, uvth}, 11'h196);
    chk(11'(flg), 11'h003);
  endtask
  task automatic t_regctl();
    for (int s = 1; s < 4; s++) begin
      i_rvp_host.wr_reg(4'hb, {1'b0, 2'(s), 6'h02, 2'(s)});
      i_rvp_host.rd_reg(4'hb, v);
      chk(v, {1'b0, 2'(s), 6'h02, 2'(s)});
      chk({7'h0, vsc, uvth}, 11'(s * 5));
    end
    i_rvp_host.wr_reg(4'h7, 11'h7ff);
    i_rvp_host.rd_reg(4'hb, v);
    chk(v, 11'h30b);
    i_rvp_host.rd_reg(4'hc, v);
    chk(v, 11'h0c8);
    i_rvp_host.wr_reg(4'hb, 11'h10a);
  endtask
  task automatic t_faults();
    i_rvp_host.wr_reg(4'hc, 11'h7f9);
    i_rvp_host.rd_reg(4'hc, v);
    chk(v, 11'h0f9);
    drive(6'h20, 1'b0);
    chk(11'(flg), 11'h0b);
    drive(6'h00, 1'b0);
    i_rvp_host.clear_faults();
    i_rvp_host.wr_reg(4'hc, 11'h0c8);
    drive(6'h04, 1'b0);
    drive(6'h00, 1'b0);
    chk(11'(flg), 11'h1b);
    i_rvp_host.sleep_req(1'b0);
    #1;
    chk(11'(flg), 11'h1b);
    i_rvp_host.clear_faults();
    #1;
    chk(11'(flg), 11'h03);
    i_rvp_host.wr_reg(4'hc, 11'h0ca);
    drive(6'h3f, 1'b0);
    chk(11'(flg), 11'h01);
    drive(6'h00, 1'b1);
    chk(11'(flg), 11'h05);
    drive(6'h00, 1'b0);
    i_rvp_host.clear_faults();
    i_rvp_host.wr_reg(4'hb, 11'h10e);
    drive(6'h00, 1'b1);
    chk(11'(flg), 11'h01);
    drive(6'h00, 1'b0);
  endtask
  task automatic t_sleep();
    int unsigned d[4] = '{0, TA, TB, TC};
    int unsigned n;
    for (int c = 0; c < 4; c++) begin
      i_rvp_host.wr_reg(4'hb, 11'h101 | 11'(c << 3));
      i_rvp_host.sleep_req(1'b1);
      n = 0;
      #1;
      while (ren === 1'b1 && n < 100) begin
        @(posedge mclk_i);
        #1;
        n++;
      end
      chk(11'(n), 11'(d[c]));
      i_rvp_host.sleep_req(1'b0);
      @(posedge mclk_i);
      #1;
      chk(11'(ren), 11'h001);
    end
  endtask
  // mid-run reset must drop a latched shutdown and restore every field
  task automatic t_rerst();
    i_rvp_host.wr_reg(4'hc, 11'h0f8);
    drive(6'h01, 1'b0);
    drive(6'h00, 1'b0);
    chk(11'(flg), 11'h1b);
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    i_rvp_host.rd_reg(4'hb, v);
    chk(v, 11'h10a);
    i_rvp_host.rd_reg(4'hc, v);
    chk(v, 11'h0c8);
    chk(11'(flg), 11'h03);
  endtask
  initial begin
    rst_n_i    = 1'b0;
    vds_trip_i = 6'h00;
    reg_uv_i   = 1'b0;
    error_cnt  = 0;
    cmp_count  = 0;
    cyc        = 0;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_regctl();
    t_faults();
    t_sleep();
    t_rerst();
    tally_and_finish();
  end
endmodule // tb
